/* File: design/ppc_regs.svh */
// Constants of the port pin configuration register bank.
// Assumes inclusion by its bare name from the package and design files.
//
// Contract
// RQ1 - Mode register pair fixes each pin's mode
// RQ2 - Reset: mode A ones, others zeros
// RQ3 - Input type bit: 0 TTL, 1 Schmitt
// RQ4 - Slew bit: 0 normal, 1 high speed
// RQ5 - Bit 7 pull-up, forced on as reset
// RQ6 - Bit 3 routes timer 1 to pin
// RQ7 - Bit 2 routes timer 0 to pin
// RQ8 - Software enables timer output in timer mode
// RQ9 - Bit 0 selects extra pin input type
// RQ10 - Shared addresses split by selected page
// RQ11 - Page bit comes from outside, default 0
// RQ12 - Pair 00 quasi, 01 push, 10 input, 11 drain
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// -----------------------------------------------------------------
// Register indices; byte address is four times the index
// -----------------------------------------------------------------
`define PPC_ADDR_W 12
`define PPC_IDX_W 10
`define PPC_IDX_PORT0_A 10'h0B1
`define PPC_IDX_PORT0_B 10'h0B2
`define PPC_IDX_PORT1_A 10'h0B3
`define PPC_IDX_PORT1_B 10'h0B4
`define PPC_IDX_EXTRA 10'h0B5

// -----------------------------------------------------------------
// Reset values and fields
// -----------------------------------------------------------------
`define PPC_RST_MODE_A 8'hFF
`define PPC_RST_ZERO 8'h00
`define PPC_EXTRA_MASK 8'h8D
`define PPC_BIT_PULLUP 7
`define PPC_BIT_T1_OE 3
`define PPC_BIT_T0_OE 2
`define PPC_BIT_SCHMITT 0
`define PPC_PAGE_0 1'b0
`define PPC_PAGE_1 1'b1

// -----------------------------------------------------------------
// Bus answer codes
// -----------------------------------------------------------------
`define PPC_RESP_OKAY 2'h0
`define PPC_RESP_DECERR 2'h3
`define PPC_DATA_ZERO 32'h00000000

`endif

/* File: design/ppc_pkg.sv */
// Types shared by the port pin configuration design files.
// Assumes the constants header sits beside it.
package ppc_pkg;
    `include "ppc_regs.svh"

    // -------------------------------------------------------------
    // Pin I/O mode, encoded as {mode A bit, mode B bit}
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        PPC_QUASI_BIDIR = 2'h0,
        PPC_PUSH_PULL = 2'h1,
        PPC_INPUT_ONLY = 2'h2,
        PPC_OPEN_DRAIN = 2'h3
    } ppc_mode_type;

    // -------------------------------------------------------------
    // Write channel states, one-hot
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        PPC_WR_COLLECT = 3'h1,
        PPC_WR_COMMIT = 3'h2,
        PPC_WR_RESP = 3'h4
    } ppc_wr_state_type;
endpackage

/* File: design/ppc_mode_decode.sv */
// Per-pin I/O mode decoder for one eight-pin port.
// Assumes mode registers on the same clock; outputs are one-hot per pin.
`timescale 1ns/100ps
`include "ppc_regs.svh"
module ppc_mode_decode (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Mode register pair
    input wire logic [7:0] mode_a,
    input wire logic [7:0] mode_b,
    // Decoded modes
    output logic [7:0] quasi_bidir,
    output logic [7:0] push_pull,
    output logic [7:0] input_only,
    output logic [7:0] open_drain
);
    import ppc_pkg::*;

    // Pair to mode; A is the high bit of the code
    function automatic ppc_mode_type pin_mode(input logic a, input logic b);
        pin_mode = ppc_mode_type'({a, b});
    endfunction

    logic [7:0] next_quasi, next_push, next_input, next_drain;

    // Decode each pin from its bit n of both registers
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            next_quasi[n] = (pin_mode(mode_a[n], mode_b[n]) == PPC_QUASI_BIDIR); // [RQ1] [RQ12]
            next_push[n] = (pin_mode(mode_a[n], mode_b[n]) == PPC_PUSH_PULL); // [RQ12]
            next_input[n] = (pin_mode(mode_a[n], mode_b[n]) == PPC_INPUT_ONLY); // [RQ12]
            next_drain[n] = (pin_mode(mode_a[n], mode_b[n]) == PPC_OPEN_DRAIN); // [RQ12]
        end
    end

    // Registered so pad drivers see glitch-free selects
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            quasi_bidir <= `PPC_RST_ZERO;
            push_pull <= `PPC_RST_ZERO;
            input_only <= `PPC_RST_MODE_A;
            open_drain <= `PPC_RST_ZERO;
        end else begin
            quasi_bidir <= next_quasi;
            push_pull <= next_push;
            input_only <= next_input;
            open_drain <= next_drain;
        end
    end
endmodule

/* File: design/ppc_port_config.sv */
// Port pin configuration register bank behind an AXI4-Lite slave.
// Assumes page select, reset-pin strap and timer outputs on clk_sys.
`timescale 1ns/100ps
`include "ppc_regs.svh"
module ppc_port_config (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // AXI4-Lite write address
    input wire logic [`PPC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [`PPC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Context from the rest of the core
    input wire logic sfr_page_sel,
    input wire logic reset_pin_disable,
    input wire logic timer0_out,
    input wire logic timer1_out,
    // Port 0 pin controls
    output logic [7:0] port0_quasi_bidir,
    output logic [7:0] port0_push_pull,
    output logic [7:0] port0_input_only,
    output logic [7:0] port0_open_drain,
    output logic [7:0] port0_schmitt_sel,
    output logic [7:0] port0_fast_slew,
    // Port 1 pin controls
    output logic [7:0] port1_quasi_bidir,
    output logic [7:0] port1_push_pull,
    output logic [7:0] port1_input_only,
    output logic [7:0] port1_open_drain,
    output logic [7:0] port1_schmitt_sel,
    output logic [7:0] port1_fast_slew,
    // Extra pin and timer pins
    output logic extra_pin_pullup_en,
    output logic extra_pin_schmitt_sel,
    output logic timer0_pin_out,
    output logic timer0_pin_oe,
    output logic timer1_pin_out,
    output logic timer1_pin_oe
);
    import ppc_pkg::*;

    // -----------------------------------------------------------------
    // Address helpers
    // -----------------------------------------------------------------

    // Word index of a byte address; low two bits ignored
    function automatic logic [`PPC_IDX_W-1:0] word_index(input logic [`PPC_ADDR_W-1:0] addr);
        word_index = addr[`PPC_ADDR_W-1:2];
    endfunction

    // True when an index falls on a mapped register
    function automatic logic is_mapped(input logic [`PPC_IDX_W-1:0] idx);
        is_mapped = (idx >= `PPC_IDX_PORT0_A) && (idx <= `PPC_IDX_EXTRA);
    endfunction

    // -----------------------------------------------------------------
    // Register storage
    // -----------------------------------------------------------------
    logic [7:0] port0_mode_sel_a;
    logic [7:0] port0_mode_sel_b;
    logic [7:0] port0_input_type;
    logic [7:0] port0_slew_ctrl;
    logic [7:0] port1_mode_sel_a;
    logic [7:0] port1_mode_sel_b;
    logic [7:0] port1_input_type;
    logic [7:0] port1_slew_ctrl;
    logic [7:0] extra_pin_settings;

    // -----------------------------------------------------------------
    // Write channel
    // -----------------------------------------------------------------
    ppc_wr_state_type wr_state;
    ppc_wr_state_type next_wr_state;
    logic aw_held;
    logic w_held;
    logic [`PPC_IDX_W-1:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic [1:0] next_bresp;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire collecting = (wr_state == PPC_WR_COLLECT);
    wire commit = (wr_state == PPC_WR_COMMIT);
    wire both_held = (aw_held || aw_fire) && (w_held || w_fire);

    // Each channel is taken once per write, in either order
    assign s_axi_awready = collecting && !aw_held;
    assign s_axi_wready = collecting && !w_held;
    assign s_axi_bvalid = (wr_state == PPC_WR_RESP);

    // Write state sequence: collect both halves, commit, answer
    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            PPC_WR_COLLECT: begin
                if (both_held) begin
                    next_wr_state = PPC_WR_COMMIT;
                end
            end
            PPC_WR_COMMIT: begin
                next_wr_state = PPC_WR_RESP;
            end
            PPC_WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = PPC_WR_COLLECT;
                end
            end
            default: begin
                next_wr_state = PPC_WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_state <= PPC_WR_COLLECT;
        end else begin
            wr_state <= next_wr_state;
        end
    end

    // Hold flags drop once the commit cycle has used them
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else if (commit) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            aw_held <= aw_held || aw_fire;
            w_held <= w_held || w_fire;
        end
    end

    // Captured address and data of the pending write
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_idx <= '0;
            wr_byte <= `PPC_RST_ZERO;
            wr_lane0 <= 1'b0;
        end else begin
            if (aw_fire) begin
                wr_idx <= word_index(s_axi_awaddr);
            end
            if (w_fire) begin
                wr_byte <= s_axi_wdata[7:0];
                wr_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    // Unmapped addresses still answer, with a decode error
    assign next_bresp = is_mapped(wr_idx) ? `PPC_RESP_OKAY : `PPC_RESP_DECERR;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_bresp <= `PPC_RESP_OKAY;
        end else if (commit) begin
            s_axi_bresp <= next_bresp;
        end
    end

    // -----------------------------------------------------------------
    // Write decode; page taken at the commit edge
    // -----------------------------------------------------------------
    wire wr_go = commit && wr_lane0;
    wire wr_page0 = (sfr_page_sel == `PPC_PAGE_0); // [RQ11]
    wire wr_p0a = wr_go && (wr_idx == `PPC_IDX_PORT0_A);
    wire wr_p0b = wr_go && (wr_idx == `PPC_IDX_PORT0_B);
    wire wr_p1a = wr_go && (wr_idx == `PPC_IDX_PORT1_A);
    wire wr_p1b = wr_go && (wr_idx == `PPC_IDX_PORT1_B);
    wire wr_ext = wr_go && (wr_idx == `PPC_IDX_EXTRA);

    // Page 0 and page 1 registers each hold their own value
    wire we_p0_mode_a = wr_p0a && wr_page0; // [RQ10]
    wire we_p0_itype = wr_p0a && !wr_page0; // [RQ10]
    wire we_p0_mode_b = wr_p0b && wr_page0; // [RQ10]
    wire we_p0_slew = wr_p0b && !wr_page0; // [RQ10]
    wire we_p1_mode_a = wr_p1a && wr_page0; // [RQ10]
    wire we_p1_itype = wr_p1a && !wr_page0; // [RQ10]
    wire we_p1_mode_b = wr_p1b && wr_page0; // [RQ10]
    wire we_p1_slew = wr_p1b && !wr_page0; // [RQ10]

    // Port 0 registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            port0_mode_sel_a <= `PPC_RST_MODE_A; // [RQ2]
            port0_mode_sel_b <= `PPC_RST_ZERO; // [RQ2]
            port0_input_type <= `PPC_RST_ZERO; // [RQ2]
            port0_slew_ctrl <= `PPC_RST_ZERO; // [RQ2]
        end else begin
            if (we_p0_mode_a) port0_mode_sel_a <= wr_byte;
            if (we_p0_mode_b) port0_mode_sel_b <= wr_byte;
            if (we_p0_itype) port0_input_type <= wr_byte;
            if (we_p0_slew) port0_slew_ctrl <= wr_byte;
        end
    end

    // Port 1 registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            port1_mode_sel_a <= `PPC_RST_MODE_A; // [RQ2]
            port1_mode_sel_b <= `PPC_RST_ZERO; // [RQ2]
            port1_input_type <= `PPC_RST_ZERO; // [RQ2]
            port1_slew_ctrl <= `PPC_RST_ZERO; // [RQ2]
        end else begin
            if (we_p1_mode_a) port1_mode_sel_a <= wr_byte;
            if (we_p1_mode_b) port1_mode_sel_b <= wr_byte;
            if (we_p1_itype) port1_input_type <= wr_byte;
            if (we_p1_slew) port1_slew_ctrl <= wr_byte;
        end
    end

    // Extra pin register has no page; unused bits never store
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            extra_pin_settings <= `PPC_RST_ZERO;
        end else if (wr_ext) begin
            extra_pin_settings <= wr_byte & `PPC_EXTRA_MASK; // [RQ9]
        end
    end

    // -----------------------------------------------------------------
    // Read channel
    // -----------------------------------------------------------------
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [`PPC_IDX_W-1:0] rd_idx = word_index(s_axi_araddr);
    wire rd_page0 = (sfr_page_sel == `PPC_PAGE_0); // [RQ11]

    // Shared addresses return the register of the current page
    wire [7:0] rd_p0a = rd_page0 ? port0_mode_sel_a : port0_input_type; // [RQ10]
    wire [7:0] rd_p0b = rd_page0 ? port0_mode_sel_b : port0_slew_ctrl; // [RQ10]
    wire [7:0] rd_p1a = rd_page0 ? port1_mode_sel_a : port1_input_type; // [RQ10]
    wire [7:0] rd_p1b = rd_page0 ? port1_mode_sel_b : port1_slew_ctrl; // [RQ10]

    wire [7:0] rd_byte =
        (rd_idx == `PPC_IDX_PORT0_A) ? rd_p0a :
        (rd_idx == `PPC_IDX_PORT0_B) ? rd_p0b :
        (rd_idx == `PPC_IDX_PORT1_A) ? rd_p1a :
        (rd_idx == `PPC_IDX_PORT1_B) ? rd_p1b :
        (rd_idx == `PPC_IDX_EXTRA) ? extra_pin_settings :
        `PPC_RST_ZERO;

    // One read in flight; a new address waits for the answer
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `PPC_DATA_ZERO;
            s_axi_rresp <= `PPC_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= is_mapped(rd_idx) ? `PPC_RESP_OKAY : `PPC_RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Pin mode decoding, one decoder per port
    // -----------------------------------------------------------------
    ppc_mode_decode u_port0_mode (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .mode_a(port0_mode_sel_a),
        .mode_b(port0_mode_sel_b),
        .quasi_bidir(port0_quasi_bidir),
        .push_pull(port0_push_pull),
        .input_only(port0_input_only),
        .open_drain(port0_open_drain)
    );

    ppc_mode_decode u_port1_mode (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .mode_a(port1_mode_sel_a),
        .mode_b(port1_mode_sel_b),
        .quasi_bidir(port1_quasi_bidir),
        .push_pull(port1_push_pull),
        .input_only(port1_input_only),
        .open_drain(port1_open_drain)
    );

    // -----------------------------------------------------------------
    // Extra pin and timer pin routing
    // -----------------------------------------------------------------

    // As a reset pin the pull-up cannot be switched off
    wire next_pullup = reset_pin_disable ?
        1'b1 : extra_pin_settings[`PPC_BIT_PULLUP]; // [RQ5]
    wire t0_en = extra_pin_settings[`PPC_BIT_T0_OE];
    wire t1_en = extra_pin_settings[`PPC_BIT_T1_OE];

    // Buffer and slew selects follow their registers directly
    assign port0_schmitt_sel = port0_input_type; // [RQ3]
    assign port1_schmitt_sel = port1_input_type; // [RQ3]
    assign port0_fast_slew = port0_slew_ctrl; // [RQ4]
    assign port1_fast_slew = port1_slew_ctrl; // [RQ4]
    assign extra_pin_schmitt_sel = extra_pin_settings[`PPC_BIT_SCHMITT]; // [RQ9]

    // Timer outputs gated and retimed; a counter-mode timer is not
    // blocked here, software is trusted to enable only in timer mode
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            extra_pin_pullup_en <= 1'b1;
            timer0_pin_out <= 1'b0;
            timer0_pin_oe <= 1'b0;
            timer1_pin_out <= 1'b0;
            timer1_pin_oe <= 1'b0;
        end else begin
            extra_pin_pullup_en <= next_pullup; // [RQ5]
            timer0_pin_out <= timer0_out && t0_en; // [RQ7] [RQ8]
            timer0_pin_oe <= t0_en; // [RQ7]
            timer1_pin_out <= timer1_out && t1_en; // [RQ6] [RQ8]
            timer1_pin_oe <= t1_en; // [RQ6]
        end
    end

    // Protection bits carry no meaning for this bank
    wire unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};
endmodule

/* File: bench/ppc_port_config_assertions.sv */
// Checker for the port pin configuration bank, seeing only its top ports.
// Assumes the constants header is on the include path; bound at the foot.
`timescale 1ns/100ps
module ppc_port_config_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and context
    input wire logic reset_pin_disable,
    input wire logic timer0_out,
    input wire logic timer1_out,
    input wire logic [7:0] port0_input_only,
    input wire logic [7:0] port1_input_only,
    input wire logic extra_pin_pullup_en,
    input wire logic timer0_pin_out,
    input wire logic timer0_pin_oe,
    input wire logic timer1_pin_out,
    input wire logic timer1_pin_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // -------------------------------------------------------------
    // Named steps
    // -------------------------------------------------------------
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence oe0_held;
        timer0_pin_oe ##1 timer0_pin_oe;
    endsequence
    sequence oe1_held;
        timer1_pin_oe ##1 timer1_pin_oe;
    endsequence

    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    // Mode A resets to ones, so every pin starts input-only
    reset_state_a:
        assert property ($rose(nrst) |-> port0_input_only == 8'hFF
            && port1_input_only == 8'hFF && extra_pin_pullup_en)
        else $error("Reset pin state wrong");
    pullup_strap_a:
        assert property (reset_pin_disable |=> extra_pin_pullup_en)
        else $error("Pull-up off while pin is reset");
    // Response two edges after both halves are taken, never earlier
    write_resp_a:
        assert property (both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("Write response timing wrong");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped");
    read_resp_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped");
    rdata_upper_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready)
        else $error("Read upper bits or address ready wrong");
    // Timer pins follow the timer only while enabled
    t0_block_a:
        assert property (!timer0_pin_oe ##1 !timer0_pin_oe |-> !timer0_pin_out)
        else $error("Timer 0 leaks to pin");
    t0_pass_a:
        assert property (oe0_held |-> timer0_pin_out == $past(timer0_out))
        else $error("Timer 0 not on pin");
    t1_block_a:
        assert property (!timer1_pin_oe ##1 !timer1_pin_oe |-> !timer1_pin_out)
        else $error("Timer 1 leaks to pin");
    t1_pass_a:
        assert property (oe1_held |-> timer1_pin_out == $past(timer1_out))
        else $error("Timer 1 not on pin");
endmodule

bind ppc_port_config ppc_port_config_assertions ppc_port_config_assertions_inst (.*);

/* File: bench/ppc_port_config_test.sv */
// Self-checking bench for the port pin configuration bank.
// Assumes the package and constants header compile first.
`timescale 1ns/100ps
`include "ppc_regs.svh"
module ppc_port_config_test;
    import ppc_pkg::*;
    logic clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, sfr_page_sel, reset_pin_disable, timer0_out, timer1_out;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] port0_quasi_bidir, port0_push_pull, port0_input_only, port0_open_drain;
    logic [7:0] port1_quasi_bidir, port1_push_pull, port1_input_only, port1_open_drain;
    logic [7:0] port0_schmitt_sel, port0_fast_slew, port1_schmitt_sel, port1_fast_slew;
    logic extra_pin_pullup_en, extra_pin_schmitt_sel, timer0_pin_out, timer0_pin_oe;
    logic timer1_pin_out, timer1_pin_oe;
    logic [7:0] mdl [2][5];
    int seed = 38702;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int k, p;
    wire [31:0] p0m = {port0_quasi_bidir, port0_push_pull, port0_input_only, port0_open_drain};
    wire [31:0] p1m = {port1_quasi_bidir, port1_push_pull, port1_input_only, port1_open_drain};
    wire [31:0] io = {port0_schmitt_sel, port0_fast_slew, port1_schmitt_sel, port1_fast_slew};
    wire [3:0] xp = {extra_pin_pullup_en, extra_pin_schmitt_sel, timer1_pin_oe, timer0_pin_oe};

    ppc_port_config ppc_port_config_inst (.*);

    // -------------------------------------------------------------
    // Clock, timer stimulus and hang guard
    // -------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Timers run in timer mode, so enabling their pins is legal
    always @(posedge clk_sys) begin
        timer0_out <= 1'($random(seed));
        timer1_out <= 1'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_resp(input logic [1:0] exp);
        check_word({30'h0, rsp}, {30'h0, exp});
    endtask
    function automatic logic [11:0] adr(input int i);
        return 12'((`PPC_IDX_PORT0_A + i) * 4);
    endfunction
    // Expected one-hot modes, quasi/push/input/drain from the top byte down
    function automatic logic [31:0] mvs(input logic [7:0] a, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            mvs[24+i] = !a[i] && !b[i];
            mvs[16+i] = !a[i] && b[i];
            mvs[8+i] = a[i] && !b[i];
            mvs[i] = a[i] && b[i];
        end
    endfunction
    // Bus tasks end one idle edge late so no signal is driven twice in a step
    task automatic bus_write(input logic [11:0] a, input logic [31:0] v, input logic [3:0] st);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic bus_read(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic check_pins();
        check_word(p0m, mvs(mdl[0][0], mdl[0][1]));
        check_word(p1m, mvs(mdl[0][2], mdl[0][3]));
        check_word(io, {mdl[1][0], mdl[1][1], mdl[1][2], mdl[1][3]});
        check_word({28'h0, xp}, {28'h0, reset_pin_disable | mdl[0][4][7], mdl[0][4][0],
            mdl[0][4][3], mdl[0][4][2]});
    endtask
    // Reads every register on both pages back to back
    task automatic check_regs();
        for (int pg = 0; pg < 2; pg++) begin
            sfr_page_sel <= pg[0];
            for (int i = 0; i < 5; i++) begin
                bus_read(adr(i));
                check_word(rd, {24'h0, (i == 4) ? mdl[0][4] : mdl[pg][i]});
                check_resp(`PPC_RESP_OKAY);
            end
        end
        check_pins();
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        mdl = '{'{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00}, '{5{8'h00}}};
    endtask

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0;
        {s_axi_wdata, s_axi_wstrb, sfr_page_sel, reset_pin_disable} = 38'h0;
        {timer0_out, timer1_out, nrst} = 3'h0;
        do_reset();
        check_regs();
        // Random bytes into random registers on a random page and strap
        for (int n = 0; n < 40; n++) begin
            k = {$random(seed)} % 5;
            p = {$random(seed)} % 2;
            d = $random(seed);
            reset_pin_disable <= 1'($random(seed));
            sfr_page_sel <= p[0];
            bus_write(adr(k), d, 4'hF);
            check_resp(`PPC_RESP_OKAY);
            if (k == 4) mdl[0][4] = d[7:0] & `PPC_EXTRA_MASK;
            else mdl[p][k] = d[7:0];
            check_pins();
        end
        check_regs();
        // Unmapped places are refused; unused extra bits read zero
        bus_write(12'h2D8, 32'hFF, 4'hF);
        check_resp(`PPC_RESP_DECERR);
        bus_read(12'h2C0);
        check_resp(`PPC_RESP_DECERR);
        bus_write(adr(4), 32'hFF, 4'hF);
        mdl[0][4] = `PPC_EXTRA_MASK;
        bus_write(adr(4), 32'h00, 4'hE);
        check_regs();
        // A second reset mid-run restores every default
        do_reset();
        check_regs();
        finish_test();
    end
endmodule
